// [hdl/lin_master_frame_scheduler.sv]
// LIN master transmit scheduler: schedule table, frame table, stream queue.
// Assumes a link controller that sends tx_req_o while tx_valid_o is high and
// pulses tx_done_i (with tx_collision_i) when the frame is over.
`timescale 1ns/1ns
`include "lin_sched_map.svh"

module lin_master_frame_scheduler
    import lin_sched_pkg::*;
#(
    parameter int NF  = 8,
    parameter int NE  = 8,
    parameter int SQD = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        tx_done_i,
    input  wire logic        tx_collision_i,
    output logic             tx_valid_o,
    output tx_req_type       tx_req_o
);
    localparam int FW = $clog2(NF);
    localparam int EW = $clog2(NE);
    localparam int QW = $clog2(SQD);

    ////////////////////////////////////////////////////////////////////////////
    // State: control, frame table, schedule table, stream queue, sequencer.
    logic            master_q, master_d, run_q, run_d, wave_q, wave_d;
    logic            wrej_q, wrej_d, srej_q, srej_d;
    logic [1:0]      stime_q, stime_d;
    logic [3:0]      nent_q, nent_d;
    logic [31:0]     time_q, time_d, dat_q, dat_d;
    logic            ack_q, ack_d;
    logic [FW-1:0]   fsel_q, fsel_d;
    logic [EW-1:0]   esel_q, esel_d, ent_q, ent_d;
    logic [5:0]      fid_q[NF], fid_d[NF];
    logic [3:0]      flen_q[NF], flen_d[NF];
    logic [63:0]     fdat_q[NF], fdat_d[NF];
    logic [NF-1:0]   fres_q[NF], fres_d[NF];
    logic [NF-1:0]   fevt_q, fevt_d, fet_q, fet_d, fnew_q, fnew_d, fsent_q, fsent_d;
    logic [NF-1:0]   emask_q[NE], emask_d[NE];
    logic [1:0]      ekind_q[NE], ekind_d[NE];
    logic [15:0]     eslot_q[NE], eslot_d[NE];
    logic [31:0]     scfg_q, scfg_d, sdat0_q, sdat0_d, sts_q, sts_d;
    logic [5:0]      qid_q[SQD], qid_d[SQD];
    logic [3:0]      qlen_q[SQD], qlen_d[SQD];
    logic [63:0]     qdat_q[SQD], qdat_d[SQD];
    logic [31:0]     qts_q[SQD], qts_d[SQD];
    logic            qet_q[SQD], qet_d[SQD];
    logic [NF-1:0]   qres_q[SQD], qres_d[SQD];
    logic [QW-1:0]   qhead_q, qhead_d, qtail_q, qtail_d;
    logic [QW:0]     qcnt_q, qcnt_d;
    logic [NF-1:0]   os_q, os_d, cres_q, cres_d;
    logic            cet_q, cet_d, cstr_q, cstr_d;
    logic [15:0]     slot_q, slot_d;
    sched_state_type st_q, st_d;
    logic            txv_q, txv_d;
    tx_req_type      req_q, req_d;

    // Returns {found, index} of the lowest set bit.
    function automatic logic [FW:0] pick(input logic [NF-1:0] m);
        logic [FW:0] r;
        r = '0;
        for (int i = NF - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, FW'(i)};
            end
        end
        return r;
    endfunction

    // Merges a bus write into a register under the byte enables.
    function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] w,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = w[8*b +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole block.
    always_comb begin
        logic          acc, wr;
        logic [5:0]    a;
        logic [31:0]   v;
        logic [FW:0]   p;
        logic [FW-1:0] f;
        logic [EW-1:0] nx;
        logic          qready;
        logic [NF-1:0] clr;
        acc = cyc_i && stb_i && !ack_q;
        wr = acc && we_i;
        a = {adr_i[5:2], 2'b00};
        v = 32'h0000_0000;
        p = '0;
        f = '0;
        nx = '0;
        clr = '0;
        master_d = master_q; run_d = run_q; wave_d = wave_q; stime_d = stime_q;
        nent_d = nent_q; wrej_d = wrej_q; srej_d = srej_q;
        time_d = time_q + 32'h0000_0001;
        fsel_d = fsel_q; esel_d = esel_q; ent_d = ent_q;
        fid_d = fid_q; flen_d = flen_q; fdat_d = fdat_q; fres_d = fres_q;
        fevt_d = fevt_q; fet_d = fet_q; fsent_d = fsent_q;
        emask_d = emask_q; ekind_d = ekind_q; eslot_d = eslot_q;
        scfg_d = scfg_q; sdat0_d = sdat0_q; sts_d = sts_q;
        qid_d = qid_q; qlen_d = qlen_q; qdat_d = qdat_q; qts_d = qts_q;
        qet_d = qet_q; qres_d = qres_q;
        qhead_d = qhead_q; qtail_d = qtail_q; qcnt_d = qcnt_q;
        os_d = os_q; cres_d = cres_q; cet_d = cet_q; cstr_d = cstr_q;
        slot_d = slot_q; st_d = st_q; txv_d = txv_q; req_d = req_q;
        ack_d = acc;
        dat_d = dat_q;

        // Scheduler: one decision at each slot boundary or at the end of a stream frame, master only.
        // A replay head waits until the free-running timer reaches its stamp.
        qready = (qcnt_q != '0) && (stime_q == ST_IMMED || time_q >= qts_q[qhead_q]);
        unique case (st_q)
            ST_IDLE: begin
                if (master_q && os_q != '0) begin
                    // Pending one-shot outranks everything else.
                    p = pick(os_q);
                    f = p[FW-1:0];
                    os_d[f] = 1'b0;
                    clr[f] = 1'b1;
                    req_d = '{fid_q[f], flen_q[f], !fnew_q[f] && fevt_q[f], fdat_q[f]};
                    txv_d = 1'b1; cet_d = 1'b0; cstr_d = 1'b0;
                    slot_d = eslot_q[ent_q];
                    st_d = ST_SEND;
                end else if (master_q && qready) begin
                    // Lowest priority one-shot: stream head, oldest first.
                    req_d.id = qid_q[qhead_q];
                    if (stime_q != ST_IMMED && qet_q[qhead_q]) begin
                        req_d.id = qdat_q[qhead_q][5:0];
                    end
                    req_d.len = qlen_q[qhead_q];
                    req_d.header_only = (qlen_q[qhead_q] == 4'h0);
                    req_d.data = qdat_q[qhead_q];
                    cet_d = qet_q[qhead_q] && stime_q == ST_IMMED;
                    cres_d = qres_q[qhead_q];
                    cstr_d = 1'b1;
                    qhead_d = qhead_q + QW'(1);
                    qcnt_d = qcnt_q - (QW+1)'(1);
                    txv_d = 1'b1;
                    st_d = ST_SEND;
                end else if (master_q && run_q) begin
                    // Continuous schedule entry.
                    // An entry count of zero walks every entry of the table.
                    nx = (32'(ent_q) + 32'h0000_0001 >=
                          ((nent_q == 4'h0) ? 32'(NE) : 32'(nent_q))) ? '0 : ent_q + EW'(1);
                    ent_d = nx;
                    slot_d = eslot_q[ent_q];
                    cstr_d = 1'b0;
                    cet_d = ekind_q[ent_q] == KIND_EVTRIG;
                    if (ekind_q[ent_q] == KIND_SPORADIC) begin
                        p = pick(emask_q[ent_q] & fnew_q);
                    end else begin
                        p = pick(emask_q[ent_q]);
                    end
                    f = p[FW-1:0];
                    cres_d = fres_q[f];
                    st_d = ST_SLOT;
                    if (p[FW]) begin
                        // Latest payload is sent; if none new, event frames, event-triggered entries and unsent frames send header only, others the old one.
                        req_d = '{fid_q[f], flen_q[f], 1'b0, fdat_q[f]};
                        if (fevt_q[f] || ekind_q[ent_q] == KIND_EVTRIG) begin
                            req_d.header_only = !fnew_q[f];
                        end else begin
                            req_d.header_only = !(fnew_q[f] || fsent_q[f]);
                        end
                        clr[f] = 1'b1;
                        if (!req_d.header_only) begin
                            fsent_d[f] = 1'b1;
                        end
                        txv_d = 1'b1;
                        st_d = ST_SEND;
                    end
                end else if (!run_q) begin
                    ent_d = '0;
                end
            end
            ST_SEND: begin
                // The slot keeps counting while the link works on the frame.
                if (slot_q != 16'h0000) begin
                    slot_d = slot_q - 16'h0001;
                end
                if (tx_done_i) begin
                    txv_d = 1'b0;
                    if (tx_collision_i && cet_q) begin
                        os_d = os_q | cres_q;
                    end
                    st_d = cstr_q ? ST_IDLE : ST_SLOT;
                end
            end
            ST_SLOT: begin
                // Leave one cycle early so the next decision falls a full slot after issue.
                if (slot_q <= 16'h0002) begin
                    st_d = ST_IDLE;
                end else begin
                    slot_d = slot_q - 16'h0001;
                end
            end
        endcase

        // Consumed payloads lose their new mark; a host write below wins.
        fnew_d = fnew_q & ~clr;

        // Register writes.
        // Except FSEL, ESEL and SDATA1, byte enables merge into the current value, so other fields keep theirs.
        if (wr) begin
            unique case (a)
                `REG_CTRL: begin
                    v = bmerge({20'h00000, nent_q, 2'b00, stime_q, 1'b0, wave_q,
                                run_q, master_q}, dat_i, sel_i);
                    master_d = v[`CTRL_MASTER];
                    run_d = v[`CTRL_RUN];
                    stime_d = v[`CTRL_STIME +: 2];
                    nent_d = v[`CTRL_NENT +: 4];
                    wave_d = v[`CTRL_WAVE] && v[`CTRL_MASTER];
                    wrej_d = v[`CTRL_WAVE] && !v[`CTRL_MASTER];
                end
                `REG_FSEL: fsel_d = dat_i[FW-1:0];
                `REG_ESEL: esel_d = dat_i[EW-1:0];
                `REG_FCFG: begin
                    v = bmerge({fres_q[fsel_q], 6'h00, fet_q[fsel_q], fevt_q[fsel_q],
                                4'h0, flen_q[fsel_q], 2'b00, fid_q[fsel_q]}, dat_i, sel_i);
                    fid_d[fsel_q] = v[5:0];
                    flen_d[fsel_q] = v[`CFG_LEN +: 4];
                    fevt_d[fsel_q] = v[`CFG_EVT];
                    fet_d[fsel_q] = v[`CFG_ETRIG];
                    fres_d[fsel_q] = v[`CFG_RES +: NF];
                end
                `REG_FDATA0: fdat_d[fsel_q][31:0] = bmerge(fdat_q[fsel_q][31:0], dat_i, sel_i);
                `REG_FDATA1: begin
                    fdat_d[fsel_q][63:32] = bmerge(fdat_q[fsel_q][63:32], dat_i, sel_i);
                    fnew_d[fsel_q] = 1'b1;
                end
                `REG_ECFG: begin
                    v = bmerge({eslot_q[esel_q], 6'h00, ekind_q[esel_q], emask_q[esel_q]},
                               dat_i, sel_i);
                    emask_d[esel_q] = v[NF-1:0];
                    ekind_d[esel_q] = v[`ECFG_KIND +: 2];
                    eslot_d[esel_q] = v[`ECFG_SLOT +: 16];
                end
                `REG_SCFG: scfg_d = bmerge(scfg_q, dat_i, sel_i);
                `REG_SDATA0: sdat0_d = bmerge(sdat0_q, dat_i, sel_i);
                `REG_SSTAMP: sts_d = bmerge(sts_q, dat_i, sel_i);
                `REG_SDATA1: begin
                    // Push one stream frame; refused as slave or when full.
                    if (!master_q || qcnt_q == (QW+1)'(SQD)) begin
                        srej_d = 1'b1;
                    end else begin
                        qid_d[qtail_q] = scfg_q[5:0];
                        qlen_d[qtail_q] = scfg_q[`CFG_LEN +: 4];
                        qet_d[qtail_q] = scfg_q[`CFG_ETRIG];
                        qres_d[qtail_q] = scfg_q[`CFG_RES +: NF];
                        qdat_d[qtail_q] = {dat_i, sdat0_q};
                        qts_d[qtail_q] = sts_q;
                        qtail_d = qtail_q + QW'(1);
                        // Counting from qcnt_d keeps a pop in this same cycle.
                        qcnt_d = qcnt_d + (QW+1)'(1);
                        srej_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Dropping to the slave role ends waveform output as well.
        if (!master_d) begin
            wave_d = 1'b0;
        end

        // Register reads; unmapped addresses read zero.
        if (acc && !we_i) begin
            unique case (a)
                `REG_CTRL: dat_d = {20'h00000, nent_q, 2'b00, stime_q, 1'b0, wave_q,
                                    run_q, master_q};
                `REG_STATUS: dat_d = {16'h0000, 8'(ent_q), 3'b000, os_q != '0,
                                      qcnt_q == (QW+1)'(SQD), srej_q, wrej_q, txv_q};
                `REG_TIME: dat_d = time_q;
                `REG_FSEL: dat_d = 32'(fsel_q);
                `REG_ESEL: dat_d = 32'(esel_q);
                `REG_FCFG: dat_d = {fres_q[fsel_q], 6'h00, fet_q[fsel_q], fevt_q[fsel_q],
                                    4'h0, flen_q[fsel_q], 2'b00, fid_q[fsel_q]};
                `REG_FDATA0: dat_d = fdat_q[fsel_q][31:0];
                `REG_FDATA1: dat_d = fdat_q[fsel_q][63:32];
                `REG_ECFG: dat_d = {eslot_q[esel_q], 6'h00, ekind_q[esel_q], emask_q[esel_q]};
                `REG_SCFG: dat_d = scfg_q;
                `REG_SDATA0: dat_d = sdat0_q;
                `REG_SSTAMP: dat_d = sts_q;
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; synchronous reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_q <= 1'b0; run_q <= 1'b0; wave_q <= 1'b0; stime_q <= 2'b00;
            nent_q <= 4'h0; wrej_q <= 1'b0; srej_q <= 1'b0; time_q <= 32'h0000_0000;
            dat_q <= 32'h0000_0000; ack_q <= 1'b0; fsel_q <= '0; esel_q <= '0;
            ent_q <= '0; fevt_q <= '0; fet_q <= '0; fnew_q <= '0; fsent_q <= '0;
            scfg_q <= 32'h0000_0000; sdat0_q <= 32'h0000_0000; sts_q <= 32'h0000_0000;
            qhead_q <= '0; qtail_q <= '0; qcnt_q <= '0; os_q <= '0; cres_q <= '0;
            cet_q <= 1'b0; cstr_q <= 1'b0; slot_q <= 16'h0000; st_q <= ST_IDLE;
            txv_q <= 1'b0; req_q <= '0;
            for (int i = 0; i < NF; i++) begin
                fid_q[i] <= 6'h00; flen_q[i] <= 4'h0; fdat_q[i] <= 64'h0; fres_q[i] <= '0;
            end
            for (int i = 0; i < NE; i++) begin
                emask_q[i] <= '0; ekind_q[i] <= 2'b00; eslot_q[i] <= `SLOT_RESET;
            end
            for (int i = 0; i < SQD; i++) begin
                qid_q[i] <= 6'h00; qlen_q[i] <= 4'h0; qdat_q[i] <= 64'h0;
                qts_q[i] <= 32'h0000_0000; qet_q[i] <= 1'b0; qres_q[i] <= '0;
            end
        end else begin
            master_q <= master_d; run_q <= run_d; wave_q <= wave_d; stime_q <= stime_d;
            nent_q <= nent_d; wrej_q <= wrej_d; srej_q <= srej_d; time_q <= time_d;
            dat_q <= dat_d; ack_q <= ack_d; fsel_q <= fsel_d; esel_q <= esel_d;
            ent_q <= ent_d; fevt_q <= fevt_d; fet_q <= fet_d; fnew_q <= fnew_d;
            fsent_q <= fsent_d; scfg_q <= scfg_d; sdat0_q <= sdat0_d; sts_q <= sts_d;
            qhead_q <= qhead_d; qtail_q <= qtail_d; qcnt_q <= qcnt_d; os_q <= os_d;
            cres_q <= cres_d; cet_q <= cet_d; cstr_q <= cstr_d; slot_q <= slot_d;
            st_q <= st_d; txv_q <= txv_d; req_q <= req_d;
            fid_q <= fid_d; flen_q <= flen_d; fdat_q <= fdat_d; fres_q <= fres_d;
            emask_q <= emask_d; ekind_q <= ekind_d; eslot_q <= eslot_d;
            qid_q <= qid_d; qlen_q <= qlen_d; qdat_q <= qdat_d; qts_q <= qts_d;
            qet_q <= qet_d; qres_q <= qres_d;
        end
    end

    // Outputs straight from flip-flops.
    assign dat_o = dat_q;
    assign ack_o = ack_q;
    assign tx_valid_o = txv_q;
    assign tx_req_o = req_q;
endmodule // lin_master_frame_scheduler

// [common/lin_sched_map.svh]
// Register map, field positions and reset values of the LIN frame scheduler.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr_i[5:0].
`ifndef LIN_SCHED_MAP_SVH
`define LIN_SCHED_MAP_SVH
`define REG_CTRL    6'h00
`define REG_STATUS  6'h04
`define REG_TIME    6'h08
`define REG_FSEL    6'h0C
`define REG_FCFG    6'h10
`define REG_FDATA0  6'h14
`define REG_FDATA1  6'h18
`define REG_ESEL    6'h1C
`define REG_ECFG    6'h20
`define REG_SCFG    6'h24
`define REG_SDATA0  6'h28
`define REG_SSTAMP  6'h2C
`define REG_SDATA1  6'h30
`define CTRL_MASTER 0
`define CTRL_RUN    1
`define CTRL_WAVE   2
`define CTRL_STIME  4
`define CTRL_NENT   8
`define CFG_LEN     8
`define CFG_EVT     16
`define CFG_ETRIG   17
`define CFG_RES     24
`define ECFG_KIND   8
`define ECFG_SLOT   16
`define SLOT_RESET  16'h03E8
`endif

// [common/lin_sched_pkg.sv]
// Types shared by the LIN frame scheduler and its surroundings.
// Assumes the link controller takes one frame request at a time.
package lin_sched_pkg;
    typedef enum {ST_IDLE, ST_SEND, ST_SLOT} sched_state_type;
    typedef enum logic [1:0] {ST_IMMED, ST_REPLAY_EXCL, ST_REPLAY_INCL} stime_type;
    typedef enum logic [1:0] {KIND_UNCOND, KIND_SPORADIC, KIND_EVTRIG} kind_type;
    typedef struct packed {
        logic [5:0]  id;
        logic [3:0]  len;
        logic        header_only;
        logic [63:0] data;
    } tx_req_type;
endpackage

// [verification/lin_sched_checker.sv]
// Checker for the LIN frame scheduler: bus answers and the frame handshake.
// Assumes it is bound to the scheduler top and sees only its ports.
`timescale 1ns/1ns
module lin_sched_checker
    import lin_sched_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [5:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0]  sel_i,
    input wire logic        we_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        tx_done_i,
    input wire logic        tx_collision_i,
    input wire logic        tx_valid_o,
    input wire tx_req_type  tx_req_o
);
    logic master_q;
    logic master_d;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    // Follows the master bit as the bus writes the control register.
    always_comb begin
        master_d = master_q;
        if (cyc_i && stb_i && we_i && ack_o && adr_i[5:2] == 4'h0 && sel_i[0]) master_d = dat_i[0];
    end
    always_ff @(posedge clk_i) master_q <= rst_i ? 1'b0 : master_d;
    // Steps of a bus request and of a frame on the link.
    sequence wb_take_s; cyc_i && stb_i && !ack_o; endsequence
    sequence frame_wait_s; tx_valid_o && !tx_done_i; endsequence
    sequence frame_end_s; tx_valid_o && tx_done_i; endsequence
    req_ack_a: assert property (wb_take_s |=> ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    read_hold_a: assert property (!(cyc_i && stb_i && !we_i) |=> $stable(dat_o))
        else $error("read data moved without a read");
    req_stable_a: assert property (frame_wait_s |=> tx_valid_o && $stable(tx_req_o))
        else $error("frame request not held");
    done_drop_a: assert property (frame_end_s |=> !tx_valid_o)
        else $error("frame request kept after done");
    slave_quiet_a: assert property ($rose(tx_valid_o) |-> master_q)
        else $error("frame issued while slave");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !tx_valid_o && !ack_o)
        else $error("outputs active after reset");
endmodule // lin_sched_checker
bind lin_master_frame_scheduler lin_sched_checker chk (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i,
    .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .tx_done_i, .tx_collision_i, .tx_valid_o, .tx_req_o);

// [verification/lin_link_model.sv]
// Link controller model: takes each frame request and ends it after a delay.
// Assumes the scheduler holds tx_valid_o until it has seen tx_done_i.
`timescale 1ns/1ns
module lin_link_model
    import lin_sched_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] delay_i,
    input  wire logic       collide_i,
    output logic            tx_done_o,
    output logic            tx_collision_o
);
    logic [7:0] cnt_q;
    logic       fin;
    ////////////////////////////////////////
    // Ends a frame with one pulse carrying collide_i; the collision line toggles outside it.
    assign fin = tx_valid_i && !tx_done_o && cnt_q >= delay_i;
    always_ff @(posedge clk_i) begin
        cnt_q <= (rst_i || !tx_valid_i || tx_done_o) ? 8'h00 : cnt_q + 8'h01;
        tx_done_o <= !rst_i && fin;
        tx_collision_o <= !rst_i && (fin ? collide_i : !tx_collision_o);
    end
endmodule // lin_link_model

// [verification/lin_master_frame_scheduler_bench.sv]
// Bench for the LIN frame scheduler: bus tasks, link model and scenarios.
// Assumes the package, the register map header and the checker are compiled.
`timescale 1ns/1ns
`include "lin_sched_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module lin_master_frame_scheduler_bench
    import lin_sched_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, vp = 1'b0, collide = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_o;
    logic        ack_o, tx_done_i, tx_collision_i, tx_valid_o;
    logic [7:0]  dly = 8'h02;
    tx_req_type  tx_req_o;
    tx_req_type  fq[$];
    int          tq[$];
    int          fails = 0, n_compared = 0, cyc_n = 0;
    ////////////////////////////////////////
    // Clock, design, link model, and a log of each new frame request.
    always #50 clk_i = ~clk_i;
    lin_master_frame_scheduler DUT (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i,
        .stb_i, .dat_o, .ack_o, .tx_done_i, .tx_collision_i, .tx_valid_o, .tx_req_o);
    lin_link_model link (.clk_i, .rst_i, .tx_valid_i(tx_valid_o), .delay_i(dly),
        .collide_i(collide), .tx_done_o(tx_done_i), .tx_collision_o(tx_collision_i));
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        vp <= tx_valid_o;
        if (tx_valid_o === 1'b1 && vp === 1'b0) begin
            fq.push_back(tx_req_o);
            tq.push_back(cyc_n);
        end
    end
    // Classic cycle: the request stands until ack is sampled high.
    task automatic wb(input logic [5:0] a, input logic [31:0] d, input logic w,
                      output logic [31:0] r);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(a, d, 1'b1, r);
    endtask
    // Waits a bounded time for the next logged frame.
    task automatic nxt(output tx_req_type f, output int t);
        int k;
        k = 0;
        while (fq.size() == 0 && k++ < 2000) @(posedge clk_i);
        f = fq.size() > 0 ? fq.pop_front() : '0;
        t = tq.size() > 0 ? tq.pop_front() : 0;
        `CHK(k < 2000, 1'b1)
    endtask
    task automatic halt();
        wr(`REG_CTRL, 32'h0000_0001);
        repeat (200) @(posedge clk_i);
        fq.delete();
        tq.delete();
    endtask
    // Slave role: waveform mode and stream pushes are refused, nothing is sent.
    task automatic t_slave();
        logic [31:0] r;
        wb(6'h3C, 32'h0, 1'b0, r);
        `CHK(r, 32'h0)
        wr(`REG_CTRL, 32'h0000_0004);
        wb(`REG_CTRL, 32'h0, 1'b0, r);
        `CHK(r, 32'h0)
        wr(`REG_SDATA1, 32'h0);
        wb(`REG_STATUS, 32'h0, 1'b0, r);
        `CHK(r[3:0], 4'h6)
        repeat (100) @(posedge clk_i);
        `CHK(fq.size(), 0)
        $display("test slave done");
    endtask
    // Immediate stream: header only, full frame, write order, no repeats.
    task automatic t_stream();
        tx_req_type f;
        int t;
        wr(`REG_CTRL, 32'h0000_0001);
        wr(`REG_SCFG, 32'h0000_0005);
        wr(`REG_SDATA1, 32'h0);
        wr(`REG_SCFG, 32'h0000_0206);
        wr(`REG_SDATA0, 32'h0000_BBAA);
        wr(`REG_SDATA1, 32'h0);
        wr(`REG_SCFG, 32'h0000_0107);
        wr(`REG_SDATA1, 32'h0);
        nxt(f, t);
        `CHK({f.id, f.header_only}, {6'h05, 1'b1})
        nxt(f, t);
        `CHK({f.id, f.len, f.header_only, f.data}, {6'h06, 4'h2, 1'b0, 64'hBBAA})
        nxt(f, t);
        `CHK(f.id, 6'h07)
        repeat (300) @(posedge clk_i);
        `CHK(fq.size(), 0)
        $display("test stream done");
    endtask
    // Replay: the frame leaves at its stamp, an event-triggered id from byte 0.
    task automatic t_replay();
        tx_req_type f;
        logic [31:0] r;
        int t, c0;
        wr(`REG_CTRL, 32'h0000_0011);
        wb(`REG_TIME, 32'h0, 1'b0, r);
        c0 = cyc_n;
        wr(`REG_SCFG, 32'h0002_083A);
        wr(`REG_SDATA0, 32'h4433_2215);
        wr(`REG_SSTAMP, r + 32'h12C);
        wr(`REG_SDATA1, 32'h8877_6655);
        nxt(f, t);
        `CHK({f.id, f.data}, {6'h15, 64'h8877_6655_4433_2215})
        `CHK((t - c0) inside {[290:310]}, 1'b1)
        $display("test replay done");
    endtask
    // Cyclic: repeat each pass with the old payload, slow link answers.
    task automatic t_cyclic();
        tx_req_type f;
        int t0, t1, k;
        dly <= 8'h14;
        wr(`REG_FCFG, 32'h0000_0811);
        wr(`REG_FDATA0, 32'h4433_2211);
        wr(`REG_FDATA1, 32'h8877_6655);
        wr(`REG_FSEL, 32'h1);
        wr(`REG_FCFG, 32'h0000_0812);
        wr(`REG_ECFG, 32'h0028_0001);
        wr(`REG_ESEL, 32'h1);
        wr(`REG_ECFG, 32'h003C_0002);
        wr(`REG_CTRL, 32'h0000_0203);
        k = 0;
        do nxt(f, t0); while (f.id !== 6'h11 && ++k < 3);
        nxt(f, t1);
        `CHK({f.id, f.header_only}, {6'h12, 1'b1})
        nxt(f, t1);
        `CHK({f.id, f.data}, {6'h11, 64'h8877_6655_4433_2211})
        `CHK(t1 - t0, 100)
        halt();
        $display("test cyclic done");
    endtask
    // Sporadic entry: one pending frame per execution, lowest position first.
    task automatic t_spor();
        tx_req_type f;
        int t;
        dly <= 8'h02;
        for (int i = 3; i < 6; i++) begin
            wr(`REG_FSEL, i);
            wr(`REG_FCFG, 32'h0000_0120 + i);
            if (i != 4) wr(`REG_FDATA1, 32'h0);
        end
        wr(`REG_ESEL, 32'h0);
        wr(`REG_ECFG, 32'h0028_0138);
        wr(`REG_CTRL, 32'h0000_0103);
        nxt(f, t);
        `CHK(f.id, 6'h23)
        nxt(f, t);
        `CHK(f.id, 6'h25)
        repeat (120) @(posedge clk_i);
        `CHK(fq.size(), 0)
        $display("test sporadic done");
    endtask
    // Event frame: payload once, then header alone; a stream collision runs its resolver.
    task automatic t_event();
        tx_req_type f;
        int t;
        wr(`REG_FSEL, 32'h6);
        wr(`REG_FCFG, 32'h0001_0126);
        wr(`REG_FDATA1, 32'h0000_0077);
        wr(`REG_ECFG, 32'h0028_0040);
        nxt(f, t);
        `CHK({f.id, f.header_only, f.data[39:32]}, {6'h26, 1'b0, 8'h77})
        nxt(f, t);
        `CHK({f.id, f.header_only}, {6'h26, 1'b1})
        halt();
        collide <= 1'b1;
        wr(`REG_SCFG, 32'h2002_0030);
        wr(`REG_SDATA1, 32'h0);
        nxt(f, t);
        `CHK(f.id, 6'h30)
        nxt(f, t);
        `CHK(f.id, 6'h25)
        collide <= 1'b0;
        $display("test event done");
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence and the watchdog.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_slave();
        t_stream();
        t_replay();
        t_cyclic();
        t_spor();
        t_event();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        summarize();
    end
endmodule // lin_master_frame_scheduler_bench
